// ==== core/icv_pkg.sv ====
package icv_pkg;

   // ------------------------------------------------------------
   // fixed vector table, 20-bit byte addresses
   // ------------------------------------------------------------
   localparam logic [19:0] VEC_UND    = 20'hFFFDC;
   localparam logic [19:0] VEC_OVF    = 20'hFFFE0;
   localparam logic [19:0] VEC_BRK    = 20'hFFFE4;
   localparam logic [19:0] VEC_AMATCH = 20'hFFFE8;
   localparam logic [19:0] VEC_SSTEP  = 20'hFFFEC;
   localparam logic [19:0] VEC_WDT    = 20'hFFFF0;
   localparam logic [19:0] VEC_DBG    = 20'hFFFF4;
   localparam logic [19:0] VEC_NMI    = 20'hFFFF8;
   localparam logic [19:0] VEC_RESET  = 20'hFFFFC;
   localparam logic [19:0] FIXED_LO   = 20'hFFFDC;
   localparam logic [7:0]  BRK_RELOC  = 8'hFF;
   localparam logic [1:0]  VEC_LAST   = 2'h3;
   localparam logic [5:0]  TRAP_USTK  = 6'h20;
   localparam logic [5:0]  PERI_FIRST = 6'h04;
   localparam int          NUM_MATCH  = 4;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_BASE   = 8'h00;
   localparam logic [7:0] OFS_MATCH0 = 8'h04;
   localparam logic [7:0] OFS_MEN    = 8'h14;
   localparam logic [7:0] OFS_MEN_HI = 8'h18;
   localparam logic [7:0] OFS_STAT   = 8'h20;
   localparam logic [7:0] OFS_MASK   = 8'h24;
   localparam logic [7:0] OFS_STATE  = 8'h28;
   localparam logic [7:0] OFS_LVL0   = 8'h40;

   // status and mask bit positions
   localparam int ST_TRAP  = 0;
   localparam int ST_NMI   = 1;
   localparam int ST_WDT   = 2;
   localparam int ST_AMAT  = 3;
   localparam int ST_PERI  = 4;
   localparam int ST_NOOVF = 5;
   localparam int ST_RELOC = 6;
   localparam int ST_W     = 7;

   typedef enum logic [1:0] {
      TK_ILLEGAL = 2'h0,
      TK_OVF     = 2'h1,
      TK_BRK     = 2'h2,
      TK_INT     = 2'h3
   } icv_trap_kind_t;

   typedef enum logic [3:0] {
      SRC_RESET = 4'h0, SRC_UND  = 4'h1, SRC_OVF   = 4'h2,
      SRC_BRK   = 4'h3, SRC_INT  = 4'h4, SRC_AMAT  = 4'h5,
      SRC_SSTEP = 4'h6, SRC_WDT  = 4'h7, SRC_DBG   = 4'h8,
      SRC_NMI   = 4'h9, SRC_PERI = 4'hA
   } icv_src_t;

   // trap request from the core, valid for one cycle
   typedef struct packed {
      logic           valid;
      icv_trap_kind_t kind;
      logic [5:0]     num;
   } icv_trap_t;

   // accepted interrupt handed back to the core
   typedef struct packed {
      icv_src_t    src;
      logic [5:0]  num;
      logic [19:0] handler;
   } icv_take_t;

endpackage

// ==== core/icv_top.sv ====
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
// Operation
// - maskable requests obey global enable and level; others ignore both
// - trap instructions are taken whatever the enable or levels, overflow only with its flag
// - illegal opcode trap vectors through the fixed entry at FFFDC
// - overflow trap is taken only when the overflow flag is 1; entry FFFE0
// - breakpoint uses entry FFFE4 unless its top byte is FF, then relocatable
// - vectored trap takes numbers 0..63; 4..31 share peripheral vectors
// - traps 0..31 save the stack select flag, clear it, restore on return
// - traps 32..63 leave the stack select flag as it is
// - pin, debugger, watchdog, single step and address match are non-maskable
// - peripheral requests are maskable, gated by enable and per-source level
// - falling edge on the unmaskable pin requests; entry FFFF8
// - enabled address match before execution vectors through FFFE8
// - each vector is 4 bytes; the core branches to the address read
// - fixed table spans FFFDC..FFFFF, reset vector at FFFFC
// - high bytes of fixed vectors also serve as the flash id code
// - relocatable table is 256 bytes from the base register
module icv_top #(
   parameter int NPER = 28
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   // register port
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [31:0]            reg_rdata,
   output logic                        irq,
   // core side
   input  wire icv_pkg::icv_trap_t     trap_req,
   input  wire logic                   ovf_flag,
   input  wire logic                   ien_flag,
   input  wire logic [2:0]             cpu_level,
   input  wire logic                   fetch_valid,
   input  wire logic [19:0]            fetch_pc,
   input  wire logic                   stk_wr,
   input  wire logic                   stk_wval,
   output logic                        busy,
   output logic                        take_valid,
   output icv_pkg::icv_take_t          take,
   output logic                        stack_sel,
   output logic                        stack_saved,
   output logic                        stack_push,
   // vector fetch memory port
   output logic                        mem_rd,
   output logic      [19:0]            mem_addr,
   input  wire logic                   mem_ack,
   input  wire logic [7:0]             mem_rdata,
   // request sources
   input  wire logic                   nmi_pin_n,
   input  wire logic                   wdt_req,
   input  wire logic                   debugger_trap,
   input  wire logic                   sstep_req,
   input  wire logic [NPER-1:0]        peri_req,
   output logic      [NPER-1:0]        peri_ack
);

   typedef enum logic [2:0] {
      S_IDLE  = 3'b001,
      S_FETCH = 3'b010,
      S_DONE  = 3'b100
   } icv_state_t;

   icv_state_t               state_q;
   icv_pkg::icv_trap_t       trap_q;
   logic [19:0]              base_q;
   logic [19:0]              match_q [icv_pkg::NUM_MATCH];
   logic [1:0]               men_q;
   logic [1:0]               men_hi_q;
   logic [2:0]               lvl_q [NPER];
   logic [icv_pkg::ST_W-1:0] stat_q;
   logic [icv_pkg::ST_W-1:0] mask_q;
   logic [icv_pkg::ST_W-1:0] stat_set;
   logic                     nmi_prev_q;
   logic                     nmi_pend_q;
   logic                     wdt_pend_q;
   logic                     dbg_pend_q;
   logic                     ss_pend_q;
   logic                     am_pend_q;
   logic                     rst_pend_q;
   logic [1:0]               byte_q;
   logic [31:0]              vec_q;
   logic [7:0]               id_q;
   icv_pkg::icv_src_t        cur_src_q;
   logic [5:0]               cur_num_q;
   logic                     cur_clru_q;
   logic [NPER-1:0]          cur_peri_q;
   // selection results
   logic                     sel_v;
   icv_pkg::icv_src_t        sel_src;
   logic [19:0]              sel_addr;
   logic [5:0]               sel_num;
   logic                     sel_clru;
   logic [NPER-1:0]          sel_peri;
   logic [3:0]               men_all;
   logic                     am_hit;
   logic [2:0]               best_lvl;
   logic                     idle;
   logic                     last_byte;
   logic                     brk_reloc;
   logic [31:0]              rd_mux;

   assign idle      = (state_q == S_IDLE);
   assign men_all   = {men_hi_q, men_q};
   assign last_byte = mem_ack && (byte_q == icv_pkg::VEC_LAST);
   // breakpoint falls back to the relocatable table on FF
   assign brk_reloc = last_byte && cur_src_q == icv_pkg::SRC_BRK
                      && mem_rdata == icv_pkg::BRK_RELOC;

   // ------------------------------------------------------------
   // request capture
   // ------------------------------------------------------------

   // address match against enabled slots only
   always_comb begin
      am_hit = 1'b0;
      for (int i = 0; i < icv_pkg::NUM_MATCH; i++) begin
         if (men_all[i] && fetch_valid && fetch_pc == match_q[i]) begin
            am_hit = 1'b1;
         end
      end
   end

   // one trap held at a time; the core waits on busy
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         trap_q <= '0;
      end else if (trap_req.valid && !trap_q.valid) begin
         // overflow trap without the flag is dropped
         trap_q.valid <= trap_req.kind != icv_pkg::TK_OVF
                         || ovf_flag;
         trap_q.kind  <= trap_req.kind;
         trap_q.num   <= trap_req.num;
      end else if (idle && sel_v && sel_src != icv_pkg::SRC_AMAT
                   && trap_q.valid && !rst_pend_q) begin
         trap_q.valid <= 1'b0;
      end
   end

   // sticky pending flags; a new event wins over the take
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         nmi_prev_q <= 1'b1;
         nmi_pend_q <= 1'b0;
         wdt_pend_q <= 1'b0;
         dbg_pend_q <= 1'b0;
         ss_pend_q  <= 1'b0;
         am_pend_q  <= 1'b0;
         rst_pend_q <= 1'b1;
      end else begin
         nmi_prev_q <= nmi_pin_n;
         if (nmi_prev_q && !nmi_pin_n) begin
            nmi_pend_q <= 1'b1;
         end else if (idle && sel_v && sel_src == icv_pkg::SRC_NMI) begin
            nmi_pend_q <= 1'b0;
         end
         if (wdt_req) begin
            wdt_pend_q <= 1'b1;
         end else if (idle && sel_v && sel_src == icv_pkg::SRC_WDT) begin
            wdt_pend_q <= 1'b0;
         end
         if (debugger_trap) begin
            dbg_pend_q <= 1'b1;
         end else if (idle && sel_v && sel_src == icv_pkg::SRC_DBG) begin
            dbg_pend_q <= 1'b0;
         end
         if (sstep_req) begin
            ss_pend_q <= 1'b1;
         end else if (idle && sel_v && sel_src == icv_pkg::SRC_SSTEP) begin
            ss_pend_q <= 1'b0;
         end
         if (am_hit) begin
            am_pend_q <= 1'b1;
         end else if (idle && sel_v && sel_src == icv_pkg::SRC_AMAT) begin
            am_pend_q <= 1'b0;
         end
         if (idle && sel_v && sel_src == icv_pkg::SRC_RESET) begin
            rst_pend_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // source selection
   // ------------------------------------------------------------

   // fixed order: reset, address match (must precede execution), traps,
   // then the non-maskable hardware sources, then peripherals
   always_comb begin
      sel_v    = 1'b1;
      sel_src  = icv_pkg::SRC_RESET;
      sel_addr = icv_pkg::VEC_RESET;
      sel_num  = '0;
      sel_clru = 1'b1;
      sel_peri = '0;
      best_lvl = '0;
      if (rst_pend_q) begin
         sel_addr = icv_pkg::VEC_RESET;
      end else if (am_pend_q) begin
         sel_src  = icv_pkg::SRC_AMAT;
         sel_addr = icv_pkg::VEC_AMATCH;
      end else if (trap_q.valid) begin
         // traps ignore the global enable and the levels
         unique case (trap_q.kind)
            icv_pkg::TK_ILLEGAL: begin
               sel_src  = icv_pkg::SRC_UND;
               sel_addr = icv_pkg::VEC_UND;
            end
            icv_pkg::TK_OVF: begin
               sel_src  = icv_pkg::SRC_OVF;
               sel_addr = icv_pkg::VEC_OVF;
            end
            icv_pkg::TK_BRK: begin
               sel_src  = icv_pkg::SRC_BRK;
               sel_addr = icv_pkg::VEC_BRK;
            end
            icv_pkg::TK_INT: begin
               sel_src  = icv_pkg::SRC_INT;
               sel_num  = trap_q.num;
               // base plus four bytes per number inside the 256 bytes
               sel_addr = base_q + {12'h000, trap_q.num, 2'b00};
               sel_clru = trap_q.num < icv_pkg::TRAP_USTK;
            end
         endcase
      end else if (nmi_pend_q) begin
         sel_src  = icv_pkg::SRC_NMI;
         sel_addr = icv_pkg::VEC_NMI;
      end else if (dbg_pend_q) begin
         sel_src  = icv_pkg::SRC_DBG;
         sel_addr = icv_pkg::VEC_DBG;
      end else if (wdt_pend_q) begin
         sel_src  = icv_pkg::SRC_WDT;
         sel_addr = icv_pkg::VEC_WDT;
      end else if (ss_pend_q) begin
         sel_src  = icv_pkg::SRC_SSTEP;
         sel_addr = icv_pkg::VEC_SSTEP;
      end else begin
         // highest level above the core's level wins, lowest index on ties
         sel_v = 1'b0;
         for (int i = 0; i < NPER; i++) begin
            if (peri_req[i] && lvl_q[i] > best_lvl
                && lvl_q[i] > cpu_level && ien_flag) begin
               best_lvl = lvl_q[i];
               sel_v    = 1'b1;
               sel_src  = icv_pkg::SRC_PERI;
               sel_num  = icv_pkg::PERI_FIRST + 6'(i);
               sel_addr = base_q + {12'h000, sel_num, 2'b00};
               sel_peri = '0;
               sel_peri[i] = 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // vector fetch sequence
   // ------------------------------------------------------------

   // four byte reads, ascending, assembled little-endian
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q    <= S_IDLE;
         byte_q     <= '0;
         vec_q      <= '0;
         mem_rd     <= 1'b0;
         mem_addr   <= '0;
         cur_src_q  <= icv_pkg::SRC_RESET;
         cur_num_q  <= '0;
         cur_clru_q <= 1'b0;
         cur_peri_q <= '0;
         take_valid <= 1'b0;
         take       <= '0;
         peri_ack   <= '0;
         busy       <= 1'b0;
         id_q       <= '0;
      end else begin
         mem_rd     <= 1'b0;
         take_valid <= 1'b0;
         peri_ack   <= '0;
         unique case (state_q)
            S_IDLE: begin
               busy <= trap_q.valid;
               if (sel_v) begin
                  state_q    <= S_FETCH;
                  busy       <= 1'b1;
                  byte_q     <= '0;
                  mem_rd     <= 1'b1;
                  mem_addr   <= sel_addr;
                  cur_src_q  <= sel_src;
                  cur_num_q  <= sel_num;
                  cur_clru_q <= sel_clru;
                  cur_peri_q <= sel_peri;
               end
            end
            S_FETCH: begin
               if (mem_ack) begin
                  vec_q[8*byte_q +: 8] <= mem_rdata;
                  if (brk_reloc) begin
                     // retry through relocatable entry 0
                     byte_q   <= '0;
                     mem_rd   <= 1'b1;
                     mem_addr <= base_q;
                     cur_src_q <= icv_pkg::SRC_INT;
                  end else if (last_byte) begin
                     state_q <= S_DONE;
                  end else begin
                     byte_q   <= byte_q + 2'd1;
                     mem_rd   <= 1'b1;
                     mem_addr <= mem_addr + 20'd1;
                  end
                  // top byte of a fixed entry doubles as id code
                  if (last_byte && mem_addr >= icv_pkg::FIXED_LO) begin
                     id_q <= mem_rdata;
                  end
               end
            end
            S_DONE: begin
               state_q      <= S_IDLE;
               busy         <= 1'b0;
               take_valid   <= 1'b1;
               take.src     <= cur_src_q;
               take.num     <= cur_num_q;
               take.handler <= vec_q[19:0];
               peri_ack     <= cur_peri_q;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // stack select flag
   // ------------------------------------------------------------

   // saved copy is what the core pushes; a write restores on return
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stack_sel   <= 1'b0;
         stack_saved <= 1'b0;
         stack_push  <= 1'b0;
      end else begin
         stack_push <= 1'b0;
         if (state_q == S_DONE && cur_clru_q) begin
            stack_saved <= stack_sel;
            stack_push  <= 1'b1;
            stack_sel   <= 1'b0;
         end else if (stk_wr) begin
            stack_sel <= stk_wval;
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------

   // event set bits for the status register
   always_comb begin
      stat_set = '0;
      stat_set[icv_pkg::ST_TRAP]  = take_valid
         && take.src inside {icv_pkg::SRC_UND, icv_pkg::SRC_OVF,
                             icv_pkg::SRC_BRK, icv_pkg::SRC_INT};
      stat_set[icv_pkg::ST_NMI]   = nmi_prev_q && !nmi_pin_n;
      stat_set[icv_pkg::ST_WDT]   = wdt_req;
      stat_set[icv_pkg::ST_AMAT]  = am_hit;
      stat_set[icv_pkg::ST_PERI]  = take_valid
                                    && take.src == icv_pkg::SRC_PERI;
      stat_set[icv_pkg::ST_NOOVF] = trap_req.valid && !trap_q.valid
         && trap_req.kind == icv_pkg::TK_OVF && !ovf_flag;
      stat_set[icv_pkg::ST_RELOC] = brk_reloc;
   end

   // configuration writes
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         base_q   <= '0;
         men_q    <= '0;
         men_hi_q <= '0;
         mask_q   <= '0;
      end else if (reg_wr) begin
         unique case (reg_addr)
            icv_pkg::OFS_BASE:   base_q   <= reg_wdata[19:0];
            icv_pkg::OFS_MEN:    men_q    <= reg_wdata[1:0];
            icv_pkg::OFS_MEN_HI: men_hi_q <= reg_wdata[1:0];
            icv_pkg::OFS_MASK:   mask_q   <= reg_wdata[icv_pkg::ST_W-1:0];
            default: ;
         endcase
      end
   end

   // match address slots and peripheral levels, one per entry
   for (genvar g = 0; g < icv_pkg::NUM_MATCH; g++) begin : g_match
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            match_q[g] <= '0;
         end else if (reg_wr
                      && reg_addr == icv_pkg::OFS_MATCH0 + 8'(4*g)) begin
            match_q[g] <= reg_wdata[19:0];
         end
      end
   end
   for (genvar g = 0; g < NPER; g++) begin : g_lvl
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            lvl_q[g] <= '0;                // level 0 keeps the source off
         end else if (reg_wr
                      && reg_addr == icv_pkg::OFS_LVL0 + 8'(4*g)) begin
            lvl_q[g] <= reg_wdata[2:0];
         end
      end
   end

   // sticky status: write one to clear, a same-cycle event stays set
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         stat_q <= '0;
         irq    <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == icv_pkg::OFS_STAT) begin
            stat_q <= (stat_q & ~reg_wdata[icv_pkg::ST_W-1:0]) | stat_set;
         end else begin
            stat_q <= stat_q | stat_set;
         end
         irq <= |(stat_q & mask_q);
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_mux = '0;
      if (reg_addr == icv_pkg::OFS_BASE) rd_mux[19:0] = base_q;
      if (reg_addr == icv_pkg::OFS_MEN) rd_mux[1:0] = men_q;
      if (reg_addr == icv_pkg::OFS_MEN_HI) rd_mux[1:0] = men_hi_q;
      if (reg_addr == icv_pkg::OFS_STAT) rd_mux[icv_pkg::ST_W-1:0] = stat_q;
      if (reg_addr == icv_pkg::OFS_MASK) rd_mux[icv_pkg::ST_W-1:0] = mask_q;
      if (reg_addr == icv_pkg::OFS_STATE) begin
         rd_mux[2:0]   = state_q;
         rd_mux[3]     = stack_sel;
         rd_mux[7:4]   = cur_src_q;
         rd_mux[15:8]  = id_q;
      end
      for (int i = 0; i < icv_pkg::NUM_MATCH; i++) begin
         if (reg_addr == icv_pkg::OFS_MATCH0 + 8'(4*i)) begin
            rd_mux[19:0] = match_q[i];
         end
      end
      for (int i = 0; i < NPER; i++) begin
         if (reg_addr == icv_pkg::OFS_LVL0 + 8'(4*i)) begin
            rd_mux[2:0] = lvl_q[i];
         end
      end
   end

   // read data stand for the one cycle after the strobe only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

endmodule

// ==== tb/icv_checker.sv ====
`timescale 1ns/100ps
// checks fetch, take and stack outputs
module icv_checker #(
   parameter int NPER = 28
) (
   input wire logic               core_clk,
   input wire logic               rst_n,
   input wire logic               reg_rd,
   input wire logic [31:0]        reg_rdata,
   input wire logic               take_valid,
   input wire icv_pkg::icv_take_t take,
   input wire logic               stack_sel,
   input wire logic               stack_push,
   input wire logic               mem_rd,
   input wire logic [19:0]        mem_addr,
   input wire logic               nmi_pin_n,
   input wire logic [NPER-1:0]    peri_ack
);
   logic [19:0] last_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // last byte asked; offset 3 skips the check
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         last_q <= 20'hFFFFF;
      else if (mem_rd)
         last_q <= mem_addr;
   end
   a_reset_fetch: assert property (
      $rose(rst_n) |=> mem_rd && mem_addr == icv_pkg::VEC_RESET)
      else $error("no reset fetch");
   a_byte_order: assert property (
      mem_rd && last_q[1:0] != 2'h3 |-> mem_addr == last_q + 20'h1)
      else $error("bytes out of order");
   a_und_vec: assert property (
      take_valid && take.src == icv_pkg::SRC_UND
      |-> last_q == icv_pkg::VEC_UND + 20'h3) else $error("bad und vector");
   a_nmi_vec: assert property (
      take_valid && take.src == icv_pkg::SRC_NMI
      |-> last_q == icv_pkg::VEC_NMI + 20'h3) else $error("bad nmi vector");
   a_push_isp: assert property (
      take_valid && take.src != icv_pkg::SRC_RESET &&
      !(take.src == icv_pkg::SRC_INT && take.num[5])
      |-> stack_push && !stack_sel) else $error("stack not switched");
   a_keep_usp: assert property (
      take_valid && take.src == icv_pkg::SRC_INT && take.num[5]
      |-> !stack_push && $stable(stack_sel)) else $error("stack changed");
   a_nmi_taken: assert property (
      $fell(nmi_pin_n) |-> ##[1:60] take_valid &&
      take.src == icv_pkg::SRC_NMI) else $error("pin edge lost");
   a_peri_ack: assert property (
      |peri_ack |-> take_valid && take.src == icv_pkg::SRC_PERI &&
      $onehot(peri_ack)) else $error("bad peripheral ack");
   a_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
   cover property (take_valid && take.src == icv_pkg::SRC_NMI);
   cover property (take_valid && take.src == icv_pkg::SRC_PERI);
   cover property (take_valid && take.num[5]);
endmodule
bind icv_top icv_checker #(.NPER(NPER)) u_chk (.core_clk, .rst_n,
   .reg_rd, .reg_rdata, .take_valid, .take, .stack_sel, .stack_push,
   .mem_rd, .mem_addr, .nmi_pin_n, .peri_ack);

// ==== tb/icv_mem_model.sv ====
`timescale 1ns/100ps
// vector memory: each byte holds its low address bits, except FFFE7, which holds FF when reloc is set
module icv_mem_model (
   input  wire logic        core_clk,
   input  wire logic        slow,
   input  wire logic        reloc,
   input  wire logic        mem_rd,
   input  wire logic [19:0] mem_addr,
   output logic             mem_ack,
   output logic [7:0]       mem_rdata
);
   logic        p_q = 1'b0;
   logic [19:0] a_q;
   logic [19:0] a;
   assign a = slow ? a_q : mem_addr;
   initial mem_ack = 1'b0;
   initial mem_rdata = 8'h5A;
   // slow mode answers late; idle data flip so stale bytes differ
   always @(posedge core_clk) begin
      p_q <= mem_rd;
      a_q <= mem_addr;
      mem_ack <= slow ? p_q : mem_rd;
      mem_rdata <= ~mem_rdata;
      if (slow ? p_q : mem_rd)
         mem_rdata <= (reloc && a == 20'hFFFE7) ? 8'hFF : a[7:0];
   end
endmodule

// ==== tb/icv_bench.sv ====
`timescale 1ns/100ps
// drives traps, pins and registers; checks takes
module icv_bench;
   logic core_clk, rst_n, reg_wr, reg_rd, irq, ovf_flag, ien_flag;
   logic fetch_valid, stk_wr, stk_wval, busy, take_valid, stack_sel;
   logic stack_saved, stack_push, mem_rd, mem_ack, nmi_pin_n, wdt_req;
   logic slow, reloc;
   logic [7:0]          reg_addr, mem_rdata;
   logic [31:0]         reg_wdata, reg_rdata;
   logic [19:0]         fetch_pc, mem_addr;
   logic [27:0]         peri_req, peri_ack;
   icv_pkg::icv_trap_t  trap_req;
   icv_pkg::icv_take_t  take;
   int                  failures, num_checks;
   icv_top uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .trap_req, .ovf_flag, .ien_flag, .cpu_level(3'h0),
      .fetch_valid, .fetch_pc, .stk_wr, .stk_wval, .busy, .take_valid,
      .take, .stack_sel, .stack_saved, .stack_push, .mem_rd, .mem_addr,
      .mem_ack, .mem_rdata, .nmi_pin_n, .wdt_req, .debugger_trap(1'b0),
      .sstep_req(1'b0), .peri_req, .peri_ack);
   icv_mem_model u_mem (.core_clk, .slow, .reloc, .mem_rd, .mem_addr,
      .mem_ack, .mem_rdata);
   // 50 MHz clock
   always #10 core_clk = ~core_clk;
   function automatic logic [19:0] hv(input logic [19:0] a);
      return {a[3:0] + 4'h2, a[7:0] + 8'h1, a[7:0]};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, s);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      chk("reg_rdata", e, reg_rdata);
   endtask
   // a trap made while one is still held is dropped, so wait for busy low
   task automatic trap(input icv_pkg::icv_trap_kind_t k, input logic [5:0] n);
      for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge core_clk);
      trap_req <= {1'b1, k, n};
      @(posedge core_clk);
      trap_req <= '0;
   endtask
   task automatic tk(input icv_pkg::icv_src_t s, input logic [19:0] h);
      for (int i = 0; i < 60 && take_valid !== 1'b1; i++) @(posedge core_clk);
      chk("take_valid", 32'h1, take_valid);
      chk("take_src", 32'(s), 32'(take.src));
      chk("handler", 32'(h), 32'(take.handler));
      @(posedge core_clk);
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      wrap_up;
   end
   // main sequence
   initial begin
      {core_clk, rst_n, reg_wr, reg_rd, ovf_flag, ien_flag} = '0;
      {fetch_valid, stk_wr, stk_wval, wdt_req, slow, reloc} = '0;
      {reg_addr, reg_wdata, fetch_pc, peri_req, trap_req} = '0;
      nmi_pin_n = 1'b1;
      failures = 0;
      num_checks = 0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      tk(icv_pkg::SRC_RESET, hv(icv_pkg::VEC_RESET));
      wr(icv_pkg::OFS_BASE, 32'h12300);
      stk_wr <= 1'b1;
      stk_wval <= 1'b1;
      @(posedge core_clk);
      stk_wr <= 1'b0;
      trap(icv_pkg::TK_INT, 6'h28);
      tk(icv_pkg::SRC_INT, hv(20'h123A0));
      chk("stack_sel", 32'h1, stack_sel);
      trap(icv_pkg::TK_INT, 6'h05);
      tk(icv_pkg::SRC_INT, hv(20'h12314));
      chk("stack_sel", 32'h0, stack_sel);
      chk("stack_saved", 32'h1, stack_saved);
      trap(icv_pkg::TK_OVF, 6'h00);
      repeat (4) @(posedge core_clk);
      rd(icv_pkg::OFS_STAT, 32'h21);
      wr(icv_pkg::OFS_MASK, 32'h20);
      @(posedge core_clk);
      chk("irq", 32'h1, irq);
      wr(icv_pkg::OFS_STAT, 32'h20);
      @(posedge core_clk);
      chk("irq", 32'h0, irq);
      rd(icv_pkg::OFS_STAT, 32'h01);
      ovf_flag <= 1'b1;
      trap(icv_pkg::TK_OVF, 6'h00);
      tk(icv_pkg::SRC_OVF, hv(icv_pkg::VEC_OVF));
      trap(icv_pkg::TK_ILLEGAL, 6'h00);
      tk(icv_pkg::SRC_UND, hv(icv_pkg::VEC_UND));
      trap(icv_pkg::TK_BRK, 6'h00);
      tk(icv_pkg::SRC_BRK, hv(icv_pkg::VEC_BRK));
      reloc <= 1'b1;
      trap(icv_pkg::TK_BRK, 6'h00);
      tk(icv_pkg::SRC_INT, hv(20'h12300));
      reloc <= 1'b0;
      slow <= 1'b1;
      nmi_pin_n <= 1'b0;
      tk(icv_pkg::SRC_NMI, hv(icv_pkg::VEC_NMI));
      nmi_pin_n <= 1'b1;
      wdt_req <= 1'b1;
      @(posedge core_clk);
      wdt_req <= 1'b0;
      tk(icv_pkg::SRC_WDT, hv(icv_pkg::VEC_WDT));
      slow <= 1'b0;
      wr(icv_pkg::OFS_MATCH0, 32'h0ABC0);
      wr(icv_pkg::OFS_MEN, 32'h1);
      fetch_pc <= 20'h0ABC0;
      fetch_valid <= 1'b1;
      @(posedge core_clk);
      fetch_valid <= 1'b0;
      tk(icv_pkg::SRC_AMAT, hv(icv_pkg::VEC_AMATCH));
      wr(icv_pkg::OFS_LVL0 + 8'h08, 32'h3);
      peri_req <= 28'h4;
      repeat (20) @(posedge core_clk);
      ien_flag <= 1'b1;
      tk(icv_pkg::SRC_PERI, hv(20'h12318));
      peri_req <= '0;
      rd(8'hFC, 32'h0);
      wrap_up;
   end
endmodule
